// *** rtl/dp_ram_map.vh ***
`ifndef DP_RAM_MAP_VH
`define DP_RAM_MAP_VH
// Geometry
`define ADDR_W 16
`define DATA_W 8
`define DEPTH 65536
`define ADDR_ZERO 16'h0000
`define ADDR_ONE 16'h0001
`define DATA_ZERO 8'h00
// Port-to-port timing in ns
`define WR_TO_RD_NS 40
`define CLK_PERIOD_NS 10
`define CLK_SKEW_NS 15
// Cycles for write-to-read visibility, rounded down
`define WR_TO_RD_CYC (`WR_TO_RD_NS / `CLK_PERIOD_NS)
// Pipelined reactivation count
`define REACT_CYC 2'h2
// Reset levels and run counter steps
`define LVL_HIGH 1'b1
`define LVL_LOW 1'b0
`define RUN_ZERO 2'h0
`define RUN_STEP 2'h1
`endif

// *** rtl/dp_ram_ports.v ***
`timescale 1ns/1ps
`include "dp_ram_map.vh"
module dp_ram_ports
(
  // Clock and reset
  input wire clk_sys,
  input wire rst,
  // Port a
  input wire [`ADDR_W-1:0] a_addr,
  input wire [`DATA_W-1:0] a_data_in,
  input wire a_read_write,
  input wire a_select_low_active,
  input wire a_select_high_active,
  input wire a_address_load_strobe_n,
  input wire a_count_advance_n,
  input wire a_count_clear_n,
  input wire a_output_enable_n,
  input wire a_output_mode_select,
  output wire [`DATA_W-1:0] a_data_out,
  output wire a_data_oe,
  output wire a_standby,
  // Port b
  input wire [`ADDR_W-1:0] b_addr,
  input wire [`DATA_W-1:0] b_data_in,
  input wire b_read_write,
  input wire b_select_low_active,
  input wire b_select_high_active,
  input wire b_address_load_strobe_n,
  input wire b_count_advance_n,
  input wire b_count_clear_n,
  input wire b_output_enable_n,
  input wire b_output_mode_select,
  output wire [`DATA_W-1:0] b_data_out,
  output wire b_data_oe,
  output wire b_standby
);

  // Shared array; not in the reset domain
  reg [`DATA_W-1:0] mem [0:`DEPTH-1];

  // Port a input registers
  reg [`ADDR_W-1:0] a_addr_ff;
  reg [`DATA_W-1:0] a_din_ff;
  reg a_rw_ff;
  reg a_sel_ff;
  reg a_ld_ff;
  reg a_adv_ff;
  reg a_clr_ff;

  // Port b input registers
  reg [`ADDR_W-1:0] b_addr_ff;
  reg [`DATA_W-1:0] b_din_ff;
  reg b_rw_ff;
  reg b_sel_ff;
  reg b_ld_ff;
  reg b_adv_ff;
  reg b_clr_ff;

  // Address counters
  reg [`ADDR_W-1:0] a_cnt_ff;
  reg [`ADDR_W-1:0] b_cnt_ff;

  // Port a output stage
  reg [`DATA_W-1:0] a_q_ff;
  reg [`DATA_W-1:0] a_dout_ff;
  reg [1:0] a_run_ff;
  reg a_pst_ff;
  reg a_oe_ff;
  reg a_stby_ff;

  // Port b output stage
  reg [`DATA_W-1:0] b_q_ff;
  reg [`DATA_W-1:0] b_dout_ff;
  reg [1:0] b_run_ff;
  reg b_pst_ff;
  reg b_oe_ff;
  reg b_stby_ff;

  // Both selects at their active level
  function port_selected;
    input sel_lo;
    input sel_hi;
    begin
      port_selected = ~sel_lo & sel_hi;
    end
  endfunction

  // Access address from registered controls
  function [`ADDR_W-1:0] access_addr;
    input clr_n;
    input ld_n;
    input adv_n;
    input [`ADDR_W-1:0] ext;
    input [`ADDR_W-1:0] cnt;
    begin
      if (!clr_n)
        access_addr = `ADDR_ZERO;
      else if (!ld_n)
        access_addr = ext;
      else if (!adv_n)
        access_addr = cnt + `ADDR_ONE;
      else
        access_addr = cnt;
    end
  endfunction

  // Consecutive selected samples, saturating at the reactivation count
  function [1:0] run_step;
    input sel;
    input [1:0] run;
    begin
      if (!sel)
        run_step = `RUN_ZERO;
      else if (run == `REACT_CYC)
        run_step = run;
      else
        run_step = run + `RUN_STEP;
    end
  endfunction

  // Output enable for the next cycle, by output mode
  function oe_next;
    input mode;
    input rd_now;
    input pipe_ready;
    input sel_now;
    begin
      if (mode)
        oe_next = pipe_ready & sel_now;
      else
        oe_next = rd_now;
    end
  endfunction

  // Output data for the next cycle, by output mode
  function [`DATA_W-1:0] dout_next;
    input mode;
    input [`DATA_W-1:0] staged;
    input [`DATA_W-1:0] direct;
    begin
      if (mode)
        dout_next = staged;
      else
        dout_next = direct;
    end
  endfunction

  // Access addresses and strobes
  wire [`ADDR_W-1:0] a_acc = access_addr(a_clr_ff, a_ld_ff, a_adv_ff, a_addr_ff, a_cnt_ff);
  wire [`ADDR_W-1:0] b_acc = access_addr(b_clr_ff, b_ld_ff, b_adv_ff, b_addr_ff, b_cnt_ff);
  wire a_wr = a_sel_ff & ~a_rw_ff;
  wire b_wr = b_sel_ff & ~b_rw_ff;
  wire a_rdok = a_sel_ff & a_rw_ff;
  wire b_rdok = b_sel_ff & b_rw_ff;
  wire [1:0] nxt_a_run = run_step(a_sel_ff, a_run_ff);
  wire [1:0] nxt_b_run = run_step(b_sel_ff, b_run_ff);
  wire nxt_a_pst = a_rdok & (nxt_a_run == `REACT_CYC);
  wire nxt_b_pst = b_rdok & (nxt_b_run == `REACT_CYC);

  // Flow-through read with same-location write bypass
  wire [`DATA_W-1:0] a_rd = (b_wr && b_acc == a_acc) ? b_din_ff : mem[a_acc];
  wire [`DATA_W-1:0] b_rd = (a_wr && a_acc == b_acc) ? a_din_ff : mem[b_acc];

  // Port a input registers
  always @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      a_addr_ff <= `ADDR_ZERO;
      a_din_ff <= `DATA_ZERO;
      a_rw_ff <= `LVL_HIGH;
      a_sel_ff <= `LVL_LOW;
      a_ld_ff <= `LVL_HIGH;
      a_adv_ff <= `LVL_HIGH;
      a_clr_ff <= `LVL_HIGH;
    end
    else
    begin
      a_addr_ff <= a_addr;
      a_din_ff <= a_data_in;
      a_rw_ff <= a_read_write;
      a_sel_ff <= port_selected(a_select_low_active, a_select_high_active);
      a_ld_ff <= a_address_load_strobe_n;
      a_adv_ff <= a_count_advance_n;
      a_clr_ff <= a_count_clear_n;
    end
  end

  // Port b input registers, same as port a
  always @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      b_addr_ff <= `ADDR_ZERO;
      b_din_ff <= `DATA_ZERO;
      b_rw_ff <= `LVL_HIGH;
      b_sel_ff <= `LVL_LOW;
      b_ld_ff <= `LVL_HIGH;
      b_adv_ff <= `LVL_HIGH;
      b_clr_ff <= `LVL_HIGH;
    end
    else
    begin
      b_addr_ff <= b_addr;
      b_din_ff <= b_data_in;
      b_rw_ff <= b_read_write;
      b_sel_ff <= port_selected(b_select_low_active, b_select_high_active);
      b_ld_ff <= b_address_load_strobe_n;
      b_adv_ff <= b_count_advance_n;
      b_clr_ff <= b_count_clear_n;
    end
  end

  // Address counters follow the access address
  always @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      a_cnt_ff <= `ADDR_ZERO;
      b_cnt_ff <= `ADDR_ZERO;
    end
    else
    begin
      a_cnt_ff <= a_acc;
      b_cnt_ff <= b_acc;
    end
  end

  // Array write in the access cycle, port b last so it wins a collision
  always @(posedge clk_sys)
  begin
    if (a_wr)
      mem[a_acc] <= a_din_ff;
    if (b_wr)
      mem[b_acc] <= b_din_ff;
  end

  // Port a output stage
  always @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      a_q_ff <= `DATA_ZERO;
      a_dout_ff <= `DATA_ZERO;
      a_run_ff <= `RUN_ZERO;
      a_pst_ff <= `LVL_LOW;
      a_oe_ff <= `LVL_LOW;
      a_stby_ff <= `LVL_HIGH;
    end
    else
    begin
      a_q_ff <= a_rd;
      a_dout_ff <= dout_next(a_output_mode_select, a_q_ff, a_rd);
      a_run_ff <= nxt_a_run;
      a_pst_ff <= nxt_a_pst;
      a_oe_ff <= oe_next(a_output_mode_select, a_rdok, a_pst_ff, a_sel_ff);
      a_stby_ff <= ~port_selected(a_select_low_active, a_select_high_active);
    end
  end

  // Port b output stage
  always @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      b_q_ff <= `DATA_ZERO;
      b_dout_ff <= `DATA_ZERO;
      b_run_ff <= `RUN_ZERO;
      b_pst_ff <= `LVL_LOW;
      b_oe_ff <= `LVL_LOW;
      b_stby_ff <= `LVL_HIGH;
    end
    else
    begin
      b_q_ff <= b_rd;
      b_dout_ff <= dout_next(b_output_mode_select, b_q_ff, b_rd);
      b_run_ff <= nxt_b_run;
      b_pst_ff <= nxt_b_pst;
      b_oe_ff <= oe_next(b_output_mode_select, b_rdok, b_pst_ff, b_sel_ff);
      b_stby_ff <= ~port_selected(b_select_low_active, b_select_high_active);
    end
  end

  // Data outputs straight from flops
  assign a_data_out = a_dout_ff;
  assign b_data_out = b_dout_ff;
  // Output enable acts asynchronously
  assign a_data_oe = ~a_output_enable_n & a_oe_ff;
  assign b_data_oe = ~b_output_enable_n & b_oe_ff;
  // Standby after one deselected cycle
  assign a_standby = a_stby_ff;
  assign b_standby = b_stby_ff;

endmodule // dp_ram_ports

// *** tb/host_port.sv ***
`timescale 1ns/1ps
module host_port #(parameter logic MD = 1'b0)
(
  // Clock
  input wire clk_sys
);
  // Port pins seen by the device
  logic [15:0] ad = 16'h0000;
  logic [7:0] di = 8'h00;
  logic [6:0] ctl = 7'h7f;
  wire md = MD;
  // Change just after an edge; same address may feed both ports
  task op(input logic [15:0] a, input logic [7:0] d, input logic [6:0] c);
    @(posedge clk_sys);
    ctl <= c;
    ad <= a;
    di <= c[6] ? ~di : d;
  endtask
endmodule // host_port

// *** tb/dp_ram_ports_chk.sv ***
`timescale 1ns/1ps
module dp_ram_ports_chk
(
  input wire clk_sys, rst, a_select_low_active, a_select_high_active, a_read_write,
  input wire a_address_load_strobe_n, a_count_advance_n, a_count_clear_n,
  input wire a_output_enable_n, a_output_mode_select, a_data_oe, a_standby,
  input wire b_select_low_active, b_select_high_active, b_output_mode_select, b_data_oe,
  input wire [7:0] a_data_out
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  wire sa = !a_select_low_active && a_select_high_active;
  wire sb = !b_select_low_active && b_select_high_active;
  wire fl = !a_output_mode_select && sa && a_read_write;
  sequence s_hold;
    fl && a_address_load_strobe_n && a_count_advance_n && a_count_clear_n;
  endsequence
  sequence s_pwake;
    b_output_mode_select && !sb ##1 sb;
  endsequence
  property p_oe_async; a_output_enable_n |-> !a_data_oe; endproperty
  a_oe_async: assert property (p_oe_async) else $error("oe not gated");
  property p_float; !sa |-> ##2 !a_data_oe; endproperty
  a_float: assert property (p_float) else $error("no float");
  property p_stby; !sa ##1 !sa |=> a_standby; endproperty
  a_stby: assert property (p_stby) else $error("no standby");
  property p_wake; sa ##1 sa |=> !a_standby; endproperty
  a_wake: assert property (p_wake) else $error("stuck standby");
  property p_flow; fl |-> ##2 (a_output_enable_n || a_data_oe); endproperty
  a_flow: assert property (p_flow) else $error("flow read no drive");
  property p_hold; s_hold ##1 s_hold |-> ##2 $stable(a_data_out); endproperty
  a_hold: assert property (p_hold) else $error("hold data moved");
  property p_pdrive; b_output_mode_select && $rose(b_data_oe) |-> $past(sb, 3) && $past(sb, 4);
  endproperty
  a_pdrive: assert property (p_pdrive) else $error("early reactivation");
  property p_pquiet; s_pwake |-> ##2 !b_data_oe [*2]; endproperty
  a_pquiet: assert property (p_pquiet) else $error("early drive");
endmodule // dp_ram_ports_chk
bind dp_ram_ports dp_ram_ports_chk u_chk (.*);

// *** tb/dp_ram_ports_tb.sv ***
`timescale 1ns/1ps
module dp_ram_ports_tb;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  wire [7:0] a_data_out, b_data_out;
  wire a_data_oe, a_standby, b_data_oe, b_standby;
  int bad_count = 0;
  int check_count = 0;
  host_port ha (.clk_sys);
  host_port #(.MD(1'b1)) hb (.clk_sys);
  dp_ram_ports u_dut (.*, .a_addr(ha.ad), .a_data_in(ha.di), .a_read_write(ha.ctl[6]),
    .a_select_low_active(ha.ctl[5]), .a_select_high_active(ha.ctl[4]),
    .a_address_load_strobe_n(ha.ctl[3]), .a_count_advance_n(ha.ctl[2]),
    .a_count_clear_n(ha.ctl[1]), .a_output_enable_n(ha.ctl[0]), .a_output_mode_select(ha.md),
    .b_addr(hb.ad), .b_data_in(hb.di), .b_read_write(hb.ctl[6]),
    .b_select_low_active(hb.ctl[5]), .b_select_high_active(hb.ctl[4]),
    .b_address_load_strobe_n(hb.ctl[3]), .b_count_advance_n(hb.ctl[2]),
    .b_count_clear_n(hb.ctl[1]), .b_output_enable_n(hb.ctl[0]), .b_output_mode_select(hb.md));
  initial forever #5 clk_sys = ~clk_sys;
  task chk(input logic [7:0] s, input logic [7:0] e);
    check_count++;
    if (s !== e)
    begin
      bad_count++;
      $display("CHECK FAILED %0t got %h exp %h", $time, s, e);
    end
  endtask
  task end_sim;
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  initial
  begin
    #5000;
    bad_count++;
    end_sim;
  end
  initial
  begin
    repeat (12) @(posedge clk_sys);
    rst <= 1'b0;
    hb.op(16'h0010, 8'h5a, 7'h16);
    hb.op(16'h0011, 8'ha5, 7'h16);
    hb.op(16'h0012, 8'hc3, 7'h16);
    hb.op(16'h0012, 8'h00, 7'h7e);
    ha.op(16'h0010, 8'h00, 7'h56);
    ha.op(16'h0011, 8'h00, 7'h56);
    ha.op(16'h0000, 8'h00, 7'h5e);
    #1 chk(a_data_out, 8'h5a);
    chk({7'h00, a_data_oe}, 8'h01);
    ha.op(16'h0000, 8'h00, 7'h5a);
    #1 chk(a_data_out, 8'ha5);
    ha.op(16'h0000, 8'h00, 7'h5e);
    #1 chk(a_data_out, 8'ha5);
    ha.op(16'h0000, 8'h00, 7'h7e);
    #1 chk(a_data_out, 8'hc3);
    ha.op(16'h0000, 8'h00, 7'h7e);
    ha.op(16'h0000, 8'h00, 7'h7f);
    #1 chk({6'h00, a_data_oe, a_standby}, 8'h01);
    ha.op(16'h0033, 8'h77, 7'h1c);
    ha.op(16'h0000, 8'h00, 7'h56);
    ha.op(16'h0000, 8'h00, 7'h5e);
    ha.op(16'h0000, 8'h00, 7'h5e);
    #1 chk(a_data_out, 8'h77);
    hb.op(16'h0010, 8'h00, 7'h56);
    hb.op(16'h0000, 8'h00, 7'h5e);
    hb.op(16'h0000, 8'h00, 7'h5e);
    hb.op(16'h0000, 8'h00, 7'h5e);
    #1 chk(b_data_out, 8'h5a);
    chk({7'h00, b_data_oe}, 8'h00);
    hb.op(16'h0000, 8'h00, 7'h5e);
    #1 chk({7'h00, b_data_oe}, 8'h01);
    hb.op(16'h0011, 8'h00, 7'h56);
    hb.op(16'h0000, 8'h00, 7'h5e);
    hb.op(16'h0000, 8'h00, 7'h5e);
    #1 chk(b_data_out, 8'h5a);
    hb.op(16'h0000, 8'h00, 7'h5e);
    #1 chk(b_data_out, 8'ha5);
    repeat (3) hb.op(16'h0000, 8'h00, 7'h7e);
    #1 chk({6'h00, b_data_oe, b_standby}, 8'h01);
    fork
      ha.op(16'h0020, 8'h00, 7'h56);
      hb.op(16'h0020, 8'h99, 7'h16);
    join
    repeat (2) ha.op(16'h0000, 8'h00, 7'h5e);
    #1 chk(a_data_out, 8'h99);
    end_sim;
  end
endmodule // dp_ram_ports_tb
